// >>> rtl/xbc_defines.svh
`ifndef XBC_DEFINES_SVH
`define XBC_DEFINES_SVH

// System clock period
`define XBC_CLK_SYS_NS     40
// Each half of the generated programming clock
`define XBC_SCLK_HALF_NS   160
// Width of the second-rank update strobe
`define XBC_UPD_LOW_NS     160
// Width of the reset pulse sent to the switch
`define XBC_RST_LOW_NS     200

// Least times round up to whole system clocks
`define XBC_HALF_CYC ((`XBC_SCLK_HALF_NS + `XBC_CLK_SYS_NS - 1) / `XBC_CLK_SYS_NS)
`define XBC_UPD_CYC  ((`XBC_UPD_LOW_NS + `XBC_CLK_SYS_NS - 1) / `XBC_CLK_SYS_NS)
`define XBC_RST_CYC  ((`XBC_RST_LOW_NS + `XBC_CLK_SYS_NS - 1) / `XBC_CLK_SYS_NS)

// Matrix layout
`define XBC_NUM_OUTPUTS    8
`define XBC_FIELD_BITS     5
`define XBC_ENABLE_POS     4
`define XBC_TOTAL_BITS     40
`define XBC_LAST_OUTPUT    3'h7
`define XBC_LAST_BIT       6'h27

`endif

// >>> rtl/xbc_pkg.sv
package xbc_pkg;

    // One-hot sequencer states
    typedef enum logic [10:0] {
        ST_IDLE   = 11'h001,
        ST_SETUP  = 11'h002,
        ST_FETCH  = 11'h004,
        ST_PUT    = 11'h008,
        ST_LO     = 11'h010,
        ST_UPD    = 11'h020,
        ST_FIN    = 11'h040,
        ST_PSETUP = 11'h080,
        ST_PLO    = 11'h100,
        ST_PHI    = 11'h200,
        ST_RST    = 11'h400
    } xbc_state_t;

    typedef logic [4:0] xbc_field_t;
    typedef logic [2:0] xbc_index_t;
    typedef logic [3:0] xbc_tmr_t;
    typedef logic [5:0] xbc_bitcnt_t;

endpackage

// >>> rtl/xbc_sync2.sv
`timescale 1ns/1ns
`default_nettype none

module xbc_sync2 (
    input  wire logic CLK_SYS_IN,
    input  wire logic NRST_IN,
    input  wire logic ASYNC_IN,
    output logic      SYNC_OUT
);

    logic meta_reg;

    // Two stages; the first is read only by the second
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            meta_reg <= 1'b0;
            SYNC_OUT <= 1'b0;
        end else begin
            meta_reg <= ASYNC_IN;
            SYNC_OUT <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/xbc_cfg_mem.sv
`timescale 1ns/1ns
`default_nettype none

`include "xbc_defines.svh"

module xbc_cfg_mem (
    input  wire logic               CLK_SYS_IN,
    input  wire logic               NRST_IN,
    input  wire logic               WR_IN,
    input  wire xbc_pkg::xbc_index_t WR_ADDR_IN,
    input  wire xbc_pkg::xbc_field_t WR_DATA_IN,
    input  wire xbc_pkg::xbc_index_t RD_ADDR_IN,
    output xbc_pkg::xbc_field_t      RD_DATA_OUT
);

    xbc_pkg::xbc_field_t mem_reg [`XBC_NUM_OUTPUTS];

    // Cleared table means every output disabled, a safe first flush
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            for (int i = 0; i < `XBC_NUM_OUTPUTS; i++) begin
                mem_reg[i] <= 5'h00;
            end
        end else if (WR_IN) begin
            mem_reg[WR_ADDR_IN] <= WR_DATA_IN;
        end
    end

    // Registered read, one cycle after the address
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            RD_DATA_OUT <= 5'h00;
        end else begin
            RD_DATA_OUT <= mem_reg[RD_ADDR_IN];
        end
    end

endmodule

`default_nettype wire

// >>> rtl/xbc_host_ctrl.sv
// Summary of operation
// - Serial loads drive mode select low throughout
// - Chip select held low for whole load
// - Data set before each falling clock; 40 bits
// - Each field goes out enable first, MSB first
// - Output seven's field first, output zero last
// - Update strobe stays high while shifting
// - Serial mode always flushes all fields first
// - One chip select line frames every load, shared by a chain
// - Chain lines shared, driven as one device
// - Chain sequence is 40 bits per device; every serial load here sends 40 bits, for one device
// - Parallel load rewrites one addressed field only
// - Parallel: mode high, update high, select low, one clock pulse low
`timescale 1ns/1ns
`default_nettype none

`include "xbc_defines.svh"

module xbc_host_ctrl (
    input  wire logic       CLK_SYS_IN,
    input  wire logic       NRST_IN,
    input  wire logic       CFG_WR_IN,
    input  wire logic [2:0] CFG_IDX_IN,
    input  wire logic       CFG_EN_IN,
    input  wire logic [3:0] CFG_SEL_IN,
    input  wire logic       SER_LOAD_IN,
    input  wire logic       PAR_LOAD_IN,
    input  wire logic       PAR_COMMIT_IN,
    input  wire logic       RESET_REQ_IN,
    input  wire logic       XB_SERIAL_OUT_IN,
    output logic            BUSY_OUT,
    output logic            DONE_OUT,
    output logic [39:0]     RDBK_OUT,
    output logic            XB_CS_N_OUT,
    output logic            XB_CLK_OUT,
    output logic            XB_UPDATE_N_OUT,
    output logic            XB_MODE_OUT,
    output logic            XB_RESET_N_OUT,
    output logic            XB_SERIAL_IN_OUT,
    output logic [2:0]      XB_OUTPUT_INDEX_OUT,
    output logic [3:0]      XB_INPUT_SELECTOR_BITS_OUT,
    output logic            XB_OUTPUT_ENABLE_BIT_OUT
);

    localparam int HALF_CYC = `XBC_HALF_CYC;
    localparam int UPD_CYC  = `XBC_UPD_CYC;
    localparam int RST_CYC  = `XBC_RST_CYC;

    xbc_pkg::xbc_state_t  state_reg;
    xbc_pkg::xbc_state_t  state_next;
    xbc_pkg::xbc_tmr_t    tmr_reg;
    xbc_pkg::xbc_tmr_t    tmr_next;
    xbc_pkg::xbc_bitcnt_t bit_cnt_reg;
    xbc_pkg::xbc_bitcnt_t bit_cnt_next;
    xbc_pkg::xbc_index_t  par_idx_reg;
    xbc_pkg::xbc_index_t  par_idx_next;
    xbc_pkg::xbc_index_t  rd_addr;
    xbc_pkg::xbc_field_t  rd_data;
    logic                 commit_reg;
    logic                 commit_next;
    logic                 sdo_sync;
    logic                 tmr_done;
    logic                 last_bit;
    logic [2:0]           bit_pos;
    logic                 clk_next;
    logic                 cs_n_next;
    logic                 upd_n_next;
    logic                 mode_next;
    logic                 rst_n_next;
    logic                 sdi_next;
    logic [39:0]          rdbk_next;
    logic [4:0]           pfield_next;

    // Output driven by a serial bit number: seven first, zero last
    function automatic xbc_pkg::xbc_index_t out_of_bit(input xbc_pkg::xbc_bitcnt_t cnt);
        out_of_bit = `XBC_LAST_OUTPUT - 3'(cnt / `XBC_FIELD_BITS);
    endfunction

    // Bit of a field by position: enable at 0, then selector high to low
    function automatic logic field_bit(input xbc_pkg::xbc_field_t f, input logic [2:0] pos);
        field_bit = f[3'(`XBC_ENABLE_POS) - pos];
    endfunction

    // Dwell of each timed state, minus one
    function automatic xbc_pkg::xbc_tmr_t tmr_load(input xbc_pkg::xbc_state_t st);
        unique case (st)
            xbc_pkg::ST_UPD: tmr_load = xbc_pkg::xbc_tmr_t'(UPD_CYC - 1);
            xbc_pkg::ST_RST: tmr_load = xbc_pkg::xbc_tmr_t'(RST_CYC - 1);
            xbc_pkg::ST_SETUP, xbc_pkg::ST_PUT, xbc_pkg::ST_LO, xbc_pkg::ST_PSETUP,
            xbc_pkg::ST_PLO, xbc_pkg::ST_PHI: tmr_load = xbc_pkg::xbc_tmr_t'(HALF_CYC - 1);
            default: tmr_load = 4'h0;
        endcase
    endfunction

    // The returning serial bit is a pin from another device
    xbc_sync2 u_sdo_sync (
        .CLK_SYS_IN (CLK_SYS_IN),
        .NRST_IN    (NRST_IN),
        .ASYNC_IN   (XB_SERIAL_OUT_IN),
        .SYNC_OUT   (sdo_sync)
    );

    // Wanted matrix setting, one field per output
    xbc_cfg_mem u_cfg_mem (
        .CLK_SYS_IN  (CLK_SYS_IN),
        .NRST_IN     (NRST_IN),
        .WR_IN       (CFG_WR_IN),
        .WR_ADDR_IN  (CFG_IDX_IN),
        .WR_DATA_IN  ({CFG_EN_IN, CFG_SEL_IN}),
        .RD_ADDR_IN  (rd_addr),
        .RD_DATA_OUT (rd_data)
    );

    // Decodes shared by sequencer and pins
    assign tmr_done = (tmr_reg == 4'h0);
    assign last_bit = (bit_cnt_reg == `XBC_LAST_BIT);
    assign bit_pos  = 3'(bit_cnt_reg % `XBC_FIELD_BITS);
    // Parallel setup keeps reading its own entry; the bit counter may point elsewhere
    assign rd_addr  = (state_reg == xbc_pkg::ST_IDLE) ? CFG_IDX_IN
                    : (state_reg == xbc_pkg::ST_PSETUP) ? par_idx_reg
                    : out_of_bit(bit_cnt_reg);

    // Sequencer; requests are only taken in idle, reset first
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            xbc_pkg::ST_IDLE: begin
                if (RESET_REQ_IN) begin
                    state_next = xbc_pkg::ST_RST;
                end else if (SER_LOAD_IN) begin
                    state_next = xbc_pkg::ST_SETUP;
                end else if (PAR_LOAD_IN) begin
                    state_next = xbc_pkg::ST_PSETUP;
                end
            end
            xbc_pkg::ST_SETUP: if (tmr_done) state_next = xbc_pkg::ST_FETCH;
            xbc_pkg::ST_FETCH: state_next = xbc_pkg::ST_PUT;
            xbc_pkg::ST_PUT: if (tmr_done) state_next = xbc_pkg::ST_LO;
            xbc_pkg::ST_LO: begin
                if (tmr_done) begin
                    state_next = last_bit ? xbc_pkg::ST_UPD : xbc_pkg::ST_FETCH;
                end
            end
            xbc_pkg::ST_UPD: if (tmr_done) state_next = xbc_pkg::ST_FIN;
            xbc_pkg::ST_FIN: state_next = xbc_pkg::ST_IDLE;
            xbc_pkg::ST_PSETUP: if (tmr_done) state_next = xbc_pkg::ST_PLO;
            xbc_pkg::ST_PLO: if (tmr_done) state_next = xbc_pkg::ST_PHI;
            xbc_pkg::ST_PHI: begin
                if (tmr_done) begin
                    state_next = commit_reg ? xbc_pkg::ST_UPD : xbc_pkg::ST_FIN;
                end
            end
            xbc_pkg::ST_RST: if (tmr_done) state_next = xbc_pkg::ST_FIN;
            default: state_next = xbc_pkg::ST_IDLE;
        endcase
    end

    // Timer reloads on each state change, else counts to zero
    assign tmr_next = (state_next != state_reg) ? tmr_load(state_next)
                    : (tmr_done ? 4'h0 : tmr_reg - 4'h1);

    // Bit counter runs 0..39 across one serial flush
    assign bit_cnt_next = (state_reg == xbc_pkg::ST_SETUP) ? 6'h00
                        : (state_reg == xbc_pkg::ST_LO && tmr_done && !last_bit)
                          ? bit_cnt_reg + 6'h01 : bit_cnt_reg;

    // Parallel target and commit choice caught with the request
    assign par_idx_next = (state_reg == xbc_pkg::ST_IDLE) ? CFG_IDX_IN : par_idx_reg;
    assign commit_next  = (state_reg == xbc_pkg::ST_IDLE) ? PAR_COMMIT_IN : commit_reg;

    // Pin levels follow the next state, so pins match state_reg
    assign clk_next   = !(state_next == xbc_pkg::ST_LO || state_next == xbc_pkg::ST_PLO);
    assign cs_n_next  = (state_next == xbc_pkg::ST_IDLE || state_next == xbc_pkg::ST_FIN
                        || state_next == xbc_pkg::ST_RST);
    assign upd_n_next = (state_next != xbc_pkg::ST_UPD);
    assign rst_n_next = (state_next != xbc_pkg::ST_RST);
    assign mode_next  = (state_next == xbc_pkg::ST_SETUP) ? 1'b0
                      : (state_next == xbc_pkg::ST_PSETUP) ? 1'b1
                      : XB_MODE_OUT;

    // Serial bit changes only while the clock is high
    assign sdi_next = (state_reg == xbc_pkg::ST_PUT) ? field_bit(rd_data, bit_pos)
                                                      : XB_SERIAL_IN_OUT;

    // Parallel field placed while the clock is still high
    assign pfield_next = (state_reg == xbc_pkg::ST_PSETUP) ? rd_data
                       : {XB_OUTPUT_ENABLE_BIT_OUT, XB_INPUT_SELECTOR_BITS_OUT};

    // Old register contents come back MSB first, caught before each fall
    assign rdbk_next = (state_reg == xbc_pkg::ST_PUT && tmr_done)
                     ? {RDBK_OUT[38:0], sdo_sync} : RDBK_OUT;

    // Sequencer state
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            state_reg   <= xbc_pkg::ST_IDLE;
            tmr_reg     <= 4'h0;
            bit_cnt_reg <= 6'h00;
            par_idx_reg <= 3'h0;
            commit_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            tmr_reg     <= tmr_next;
            bit_cnt_reg <= bit_cnt_next;
            par_idx_reg <= par_idx_next;
            commit_reg  <= commit_next;
        end
    end

    // Pins idle with clock and strobes high; one set of lines serves one device, 40 bits per serial load
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            XB_CLK_OUT       <= 1'b1;
            XB_CS_N_OUT      <= 1'b1;
            XB_UPDATE_N_OUT  <= 1'b1;
            XB_RESET_N_OUT   <= 1'b1;
            XB_MODE_OUT      <= 1'b0;
            XB_SERIAL_IN_OUT <= 1'b0;
        end else begin
            XB_CLK_OUT       <= clk_next;
            XB_CS_N_OUT      <= cs_n_next;
            XB_UPDATE_N_OUT  <= upd_n_next;
            XB_RESET_N_OUT   <= rst_n_next;
            XB_MODE_OUT      <= mode_next;
            XB_SERIAL_IN_OUT <= sdi_next;
        end
    end

    // Parallel lines and user status
    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
            XB_OUTPUT_INDEX_OUT        <= 3'h0;
            XB_INPUT_SELECTOR_BITS_OUT <= 4'h0;
            XB_OUTPUT_ENABLE_BIT_OUT   <= 1'b0;
            BUSY_OUT                   <= 1'b0;
            DONE_OUT                   <= 1'b0;
            RDBK_OUT                   <= 40'h00_0000_0000;
        end else begin
            XB_OUTPUT_INDEX_OUT        <= par_idx_next;
            {XB_OUTPUT_ENABLE_BIT_OUT, XB_INPUT_SELECTOR_BITS_OUT} <= pfield_next;
            BUSY_OUT                   <= (state_next != xbc_pkg::ST_IDLE);
            DONE_OUT                   <= (state_next == xbc_pkg::ST_FIN);
            RDBK_OUT                   <= rdbk_next;
        end
    end

    // Checking helpers: falling clock edges seen in one serial flush
    logic [5:0] fall_cnt_reg;
    logic       in_shift;
    logic       in_par;

    assign in_shift = (state_reg == xbc_pkg::ST_FETCH || state_reg == xbc_pkg::ST_PUT
                       || state_reg == xbc_pkg::ST_LO);
    assign in_par   = (state_reg == xbc_pkg::ST_PSETUP || state_reg == xbc_pkg::ST_PLO
                       || state_reg == xbc_pkg::ST_PHI);

    always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN || state_reg == xbc_pkg::ST_SETUP) begin
            fall_cnt_reg <= 6'h00;
        end else if (XB_CLK_OUT && !clk_next) begin
            fall_cnt_reg <= fall_cnt_reg + 6'h01;
        end
    end

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!NRST_IN);

    sequence s_clk_low_half;
        !XB_CLK_OUT [*4];
    endsequence

    sequence s_clk_back_high;
        XB_CLK_OUT && !XB_CS_N_OUT;
    endsequence

    a_serial_mode_low: assert property (
        (state_reg == xbc_pkg::ST_SETUP || in_shift) |-> !XB_MODE_OUT && !XB_CS_N_OUT)
        else $error("mode select or select not low during serial load");

    a_select_whole_load: assert property (
        $fell(XB_CS_N_OUT) |-> !XB_CS_N_OUT [*8])
        else $error("chip select released too early");

    a_data_before_fall: assert property (
        ($fell(XB_CLK_OUT) && !XB_MODE_OUT) |-> $stable(XB_SERIAL_IN_OUT) && $past(XB_CLK_OUT, 2))
        else $error("serial data moved at a falling clock");

    a_forty_falls: assert property (
        $fell(XB_UPDATE_N_OUT) && !XB_MODE_OUT |-> fall_cnt_reg == 6'h28)
        else $error("update without exactly forty serial bits");

    a_enable_bit_first: assert property (
        (state_reg == xbc_pkg::ST_PUT && $past(state_reg) == xbc_pkg::ST_PUT && bit_pos == 3'h0)
        |-> XB_SERIAL_IN_OUT == rd_data[4])
        else $error("field not started with the enable bit");

    a_fields_descend: assert property (
        (state_reg == xbc_pkg::ST_PUT) |-> (bit_cnt_reg != 6'h00 || rd_addr == 3'h7)
                                          && (bit_cnt_reg != 6'h27 || rd_addr == 3'h0))
        else $error("fields not sent from output seven down to zero");

    a_update_high_shift: assert property (
        in_shift |-> XB_UPDATE_N_OUT)
        else $error("update strobe low while shifting");

    a_par_setup_levels: assert property (
        in_par |-> XB_MODE_OUT && XB_UPDATE_N_OUT && !XB_CS_N_OUT)
        else $error("parallel load pin levels wrong");

    a_par_clock_pulse: assert property (
        ($fell(XB_CLK_OUT) && XB_MODE_OUT) |-> $stable(XB_OUTPUT_INDEX_OUT)
        ##0 s_clk_low_half ##1 s_clk_back_high)
        else $error("parallel clock pulse malformed");

endmodule

`default_nettype wire

// >>> dv/xbc_switch_model.sv
`timescale 1ns/1ns
`default_nettype none

module xbc_switch_model #(
    parameter logic [39:0] INIT_PATTERN = 40'h9C36E15A0F // Power-up content, arbitrary
) (
    input  wire logic        cs_n_in,
    input  wire logic        clk_in,
    input  wire logic        update_n_in,
    input  wire logic        mode_in,
    input  wire logic        reset_n_in,
    input  wire logic        serial_in_in,
    input  wire logic [2:0]  index_in,
    input  wire logic [3:0]  selector_in,
    input  wire logic        enable_in,
    output logic             serial_out_out,
    output logic [39:0]      shift_out,
    output logic [39:0]      latch_out,
    output logic [7:0]       err_count_out
);
    int shifts = 0;

    // First rank is not cleared by anything, so it wakes with junk
    initial shift_out = INIT_PATTERN;
    initial err_count_out = 8'h00;

    // Serial shift on falling clock; output 7 field ends at the top
    always @(negedge clk_in) begin
        if (!cs_n_in && !mode_in) begin
            shift_out = {shift_out[38:0], serial_in_in};
            shifts++;
            if (!update_n_in) err_count_out++;
        end
    end

    // Parallel load is level sensitive while clock low
    always @* begin
        if (!cs_n_in && mode_in && !clk_in)
            shift_out[5*index_in +: 5] = {enable_in, selector_in};
    end

    // Field is enable then selector; zero enable routes nothing
    always @* begin
        if (!reset_n_in) latch_out = 40'h0000000000;
        else if (!cs_n_in && !update_n_in) latch_out = shift_out;
    end

    // Update in serial mode needs a whole frame, partial loads are junk
    always @(negedge update_n_in) begin
        if (!cs_n_in && !mode_in && shifts % 40 != 0) err_count_out++;
    end
    always @(posedge cs_n_in) shifts = 0;

    // Top bit of the first rank feeds the next device
    assign serial_out_out = shift_out[39];
endmodule

`default_nettype wire

// >>> dv/xbc_host_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none

module xbc_host_ctrl_test;
    localparam logic [39:0] INIT_PATTERN = 40'h9C36E15A0F; // Arbitrary power-up content
    localparam int LIMIT = 4000;

    typedef struct {
        logic [39:0] lat;
        logic [39:0] sr;
        logic [39:0] rdbk;
        logic        chk_rdbk;
    } xbc_note_t;

    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cfg_wr = 1'b0;
    logic [2:0]  cfg_idx = 3'h0;
    logic        cfg_en = 1'b0;
    logic [3:0]  cfg_sel = 4'h0;
    logic        ser_load = 1'b0;
    logic        par_load = 1'b0;
    logic        par_commit = 1'b0;
    logic        reset_req = 1'b0;
    logic        xb_sout;
    logic        busy, done, cs_n, xclk, upd_n, mode, rst_n, sin, oen;
    logic [39:0] rdbk, shift, lat;
    logic [2:0]  oidx;
    logic [3:0]  osel;
    logic [7:0]  errc;
    logic [4:0]  tbl [8];
    logic [39:0] exp_sr = INIT_PATTERN;
    logic [39:0] exp_lat = 40'h0000000000;
    xbc_note_t   notes [$];
    xbc_note_t   nt_m;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          i, pass;

    always #20 clk = ~clk;

    xbc_host_ctrl dut_u (.CLK_SYS_IN(clk), .NRST_IN(nrst), .CFG_WR_IN(cfg_wr),
        .CFG_IDX_IN(cfg_idx), .CFG_EN_IN(cfg_en), .CFG_SEL_IN(cfg_sel),
        .SER_LOAD_IN(ser_load), .PAR_LOAD_IN(par_load), .PAR_COMMIT_IN(par_commit),
        .RESET_REQ_IN(reset_req), .XB_SERIAL_OUT_IN(xb_sout), .BUSY_OUT(busy),
        .DONE_OUT(done), .RDBK_OUT(rdbk), .XB_CS_N_OUT(cs_n), .XB_CLK_OUT(xclk),
        .XB_UPDATE_N_OUT(upd_n), .XB_MODE_OUT(mode), .XB_RESET_N_OUT(rst_n),
        .XB_SERIAL_IN_OUT(sin), .XB_OUTPUT_INDEX_OUT(oidx),
        .XB_INPUT_SELECTOR_BITS_OUT(osel), .XB_OUTPUT_ENABLE_BIT_OUT(oen));

    xbc_switch_model #(.INIT_PATTERN(INIT_PATTERN)) sw_u (.cs_n_in(cs_n), .clk_in(xclk),
        .update_n_in(upd_n), .mode_in(mode), .reset_n_in(rst_n), .serial_in_in(sin),
        .index_in(oidx), .selector_in(osel), .enable_in(oen), .serial_out_out(xb_sout),
        .shift_out(shift), .latch_out(lat), .err_count_out(errc));

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle table write, mirrored in the bench table
    task automatic wr_entry(input logic [2:0] idx, input logic [4:0] f);
        cfg_wr = 1'b1;
        cfg_idx = idx;
        {cfg_en, cfg_sel} = f;
        @(negedge clk);
        cfg_wr = 1'b0;
        tbl[idx] = f;
        // Let an edge pass so the next call does not re-raise the strobe at once
        @(negedge clk);
    endtask

    // Note the expected outcome, pulse the request, wait for idle
    task automatic run(input logic r, input logic s, input logic p, input logic c,
                       input logic [2:0] idx, input logic poke);
        xbc_note_t nt;
        int k;
        nt.rdbk = exp_sr;
        nt.chk_rdbk = !r && s;
        if (r) begin
            exp_lat = 40'h0000000000;
        end else if (s) begin
            for (k = 0; k < 8; k++) exp_sr[5*k +: 5] = tbl[k];
            exp_lat = exp_sr;
        end else begin
            exp_sr[5*idx +: 5] = tbl[idx];
            if (c) exp_lat = exp_sr;
        end
        nt.lat = exp_lat;
        nt.sr = exp_sr;
        notes.push_back(nt);
        {reset_req, ser_load, par_load, par_commit} = {r, s, p, c};
        cfg_idx = idx;
        @(negedge clk);
        {reset_req, ser_load, par_load, par_commit} = 4'h0;
        for (k = 0; k < 4 && busy !== 1'b1; k++) @(negedge clk);
        // A request while busy must not start a second sequence
        if (poke) begin
            @(negedge clk);
            ser_load = 1'b1;
            @(negedge clk);
            ser_load = 1'b0;
        end
        for (k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge clk);
    endtask

    // Each done pulse retires the oldest note
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                check(40'h0000000001, 40'h0000000000); // Unexpected extra sequence
            end else begin
                nt_m = notes.pop_front();
                check(lat, nt_m.lat);
                check(shift, nt_m.sr);
                if (nt_m.chk_rdbk) check(rdbk, nt_m.rdbk);
            end
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'h40B2));
        for (i = 0; i < 8; i++) tbl[i] = 5'h00;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        // Reset outranks both loads and spares the first rank
        run(1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 1'b0);
        // Multicast pass first, then random full flushes back to back
        for (pass = 0; pass < 3; pass++) begin
            for (i = 0; i < 8; i++) wr_entry(i[2:0], (pass == 0) ? 5'h1F : 5'($urandom));
            run(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
        end
        // Staged parallel loads at both ends of the index range, then a commit, a reset, a second commit and a flush
        for (i = 0; i < 8; i += 7) begin
            wr_entry(i[2:0], 5'($urandom));
            run(1'b0, 1'b0, 1'b1, 1'b0, i[2:0], 1'b1);
        end
        wr_entry(3'h3, 5'h0C);
        run(1'b0, 1'b0, 1'b1, 1'b1, 3'h3, 1'b0);
        run(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0);
        wr_entry(3'h5, 5'h1A);
        run(1'b0, 1'b0, 1'b1, 1'b1, 3'h5, 1'b0);
        run(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
        repeat (4) @(negedge clk);
        check({32'h00000000, errc}, 40'h0000000000);
        check(40'(notes.size()), 40'h0000000000);
        report_and_stop();
    end
endmodule

`default_nettype wire
